// ---- shared/acc_pkg.sv ----
/*
  Constants, register map and types for the converter control block.
  Assumes a 32-bit APB bus and a single 125 MHz core clock.
*/
`default_nettype none
package acc_pkg;
  // Bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Result width and pin count
  localparam int RES_W = 10;
  localparam int NUM_PINS = 4;
  // Register byte offsets
  localparam logic [7:0] OFS_SC1 = 8'h00;
  localparam logic [7:0] OFS_SC2 = 8'h04;
  localparam logic [7:0] OFS_RES_HI = 8'h08;
  localparam logic [7:0] OFS_RES_LO = 8'h0c;
  localparam logic [7:0] OFS_CMP = 8'h10;
  localparam logic [7:0] OFS_CFG = 8'h14;
  localparam logic [7:0] OFS_PIN = 8'h18;
  // Status and control one fields
  localparam int SC1_DONE = 7;
  localparam int SC1_IEN = 6;
  localparam int SC1_CONT = 5;
  // Status and control two fields
  localparam int SC2_ACT = 7;
  localparam int SC2_HWT = 6;
  localparam int SC2_CMPE = 5;
  localparam int SC2_CMPGE = 4;
  // Configuration fields
  localparam int CFG_LPWR = 7;
  localparam int CFG_LSMP = 4;
  localparam int CFG_TEN = 2;
  // Reset values
  localparam logic [4:0] SC1_CH_RST = 5'h1f;
  localparam logic [1:0] CFG_CLK_RST = 2'h0;
  // Channel codes
  localparam logic [4:0] CH_PIN_LAST = 5'h03;
  localparam logic [4:0] CH_RSV_FIRST = 5'h16;
  localparam logic [4:0] CH_RSV_LAST = 5'h19;
  localparam logic [4:0] CH_TEMP = 5'h1a;
  localparam logic [4:0] CH_BANDGAP = 5'h1b;
  localparam logic [4:0] CH_OFF = 5'h1f;
  // Conversion clock sources
  localparam logic [1:0] CLK_BUS = 2'h0;
  localparam logic [1:0] CLK_BUS_DIV2 = 2'h1;
  localparam logic [1:0] CLK_ALT = 2'h2;
  localparam logic [1:0] CLK_LOCAL = 2'h3;
  // Sample lengths in conversion ticks, minus one
  localparam logic [4:0] SAMPLE_SHORT = 5'h03;
  localparam logic [4:0] SAMPLE_LONG = 5'h13;
  // Core cycles a trial code settles before it is judged
  localparam logic [4:0] SETTLE = 5'h02;
  // Engine states
  typedef enum logic [2:0] {
    ENG_IDLE = 3'b001,
    ENG_SAMPLE = 3'b010,
    ENG_CONVERT = 3'b100
  } acc_eng_e;
endpackage : acc_pkg
`default_nettype wire

// ---- shared/acc_sar_if.sv ----
/*
  Link between the control top and the successive approximation engine.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface acc_sar_if;
  logic start;      // Begin a sample and conversion
  logic abort;      // Drop any conversion now
  logic tick;       // Conversion clock enable
  logic long_sample; // Long sample selected
  logic cmp_above;  // Synchronised comparator result
  logic busy;       // Engine not idle
  logic done;       // One-cycle end of conversion
  logic sample_en;  // Sample switch closed
  logic [9:0] result; // Last finished code
  logic [9:0] dac_code; // Trial code to the DAC
  modport ctrl (output start, abort, tick, long_sample, cmp_above,
                input busy, done, sample_en, result, dac_code);
  modport eng (input start, abort, tick, long_sample, cmp_above,
               output busy, done, sample_en, result, dac_code);
endinterface : acc_sar_if
`default_nettype wire

// ---- hdl/acc_sar_engine.sv ----
/*
  Successive approximation sequencer: sample, then ten trial bits.
  Assumes ticks and a synchronised comparator from the control top.
*/
`timescale 1ns/100ps
`default_nettype none
module acc_sar_engine (
  input wire logic core_clk,
  input wire logic rst_b,
  acc_sar_if.eng sar
);
  import acc_pkg::*;

  acc_eng_e state_reg, state_next; // Sequencer state
  logic [4:0] cnt_reg, cnt_next;   // Sample or settle count
  logic [3:0] bit_reg, bit_next;   // Bit under trial
  logic [9:0] code_reg, code_next; // Trial code
  logic [9:0] res_reg, res_next;   // Finished result
  logic done_reg, done_next;       // End pulse
  logic smp_reg, smp_next;         // Sample switch

  // Next state of the sequencer
  always_comb begin
    acc_eng_e st;
    logic [9:0] kept;
    st = sar.abort ? ENG_IDLE : state_reg; // Abort wins
    state_next = st;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    code_next = code_reg;
    res_next = res_reg;
    done_next = 1'b0;
    smp_next = sar.abort ? 1'b0 : smp_reg;
    kept = sar.cmp_above ? code_reg : code_reg ^ (10'h001 << bit_reg);
    case (st)
      ENG_IDLE: begin
        // Wait for a start
        if (sar.start) begin
          state_next = ENG_SAMPLE;
          cnt_next = sar.long_sample ? SAMPLE_LONG : SAMPLE_SHORT;
          smp_next = 1'b1;
        end
      end
      ENG_SAMPLE: begin
        // Hold the input for the sample length
        if (sar.tick) begin
          if (cnt_reg == 5'h00) begin
            state_next = ENG_CONVERT;
            bit_next = 4'h9;
            code_next = 10'h200;
            cnt_next = SETTLE;
            smp_next = 1'b0;
          end else begin
            cnt_next = cnt_reg - 5'h01;
          end
        end
      end
      ENG_CONVERT: begin
        // Judge one bit per tick once settled
        if (cnt_reg != 5'h00) begin
          cnt_next = cnt_reg - 5'h01;
        end else if (sar.tick) begin
          if (bit_reg == 4'h0) begin
            res_next = kept;
            code_next = kept;
            done_next = 1'b1;
            state_next = ENG_IDLE;
          end else begin
            bit_next = bit_reg - 4'h1;
            code_next = kept | (10'h001 << (bit_reg - 4'h1));
            cnt_next = SETTLE;
          end
        end
      end
      default: begin
        state_next = ENG_IDLE;
      end
    endcase
  end

  // Register the sequencer
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_reg <= ENG_IDLE;
      cnt_reg <= 5'h00;
      bit_reg <= 4'h0;
      code_reg <= 10'h000;
      res_reg <= 10'h000;
      done_reg <= 1'b0;
      smp_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      code_reg <= code_next;
      res_reg <= res_next;
      done_reg <= done_next;
      smp_reg <= smp_next;
    end
  end

  // Engine outputs
  assign sar.busy = (state_reg != ENG_IDLE);
  assign sar.done = done_reg;
  assign sar.sample_en = smp_reg;
  assign sar.result = res_reg;
  assign sar.dac_code = code_reg;
endmodule : acc_sar_engine
`default_nettype wire

// ---- hdl/acc_top.sv ----
/*
  Converter control top: APB registers, channel map, clock choice,
  hardware trigger, single and continuous runs, compare and done flag.
  Assumes an APB master on core_clk and analog pins from outside.
*/
`timescale 1ns/100ps
`default_nettype none
module acc_top (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [acc_pkg::ADDR_W-1:0] paddr,
  input wire logic [acc_pkg::DATA_W-1:0] pwdata,
  output logic [acc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmp_above_pin,
  input wire logic local_async_conv_clock,
  input wire logic hw_conversion_trigger,
  output logic [4:0] channel_select,
  output logic [acc_pkg::NUM_PINS-1:0] pin_route,
  output logic [acc_pkg::NUM_PINS-1:0] pin_enable,
  output logic temp_sensor_sel,
  output logic bandgap_sel,
  output logic sar_power_on,
  output logic sample_en,
  output logic [acc_pkg::RES_W-1:0] dac_code,
  output logic conv_irq
);
  import acc_pkg::*;

  // True when the channel code switches the converter off
  // Shared by the start, abort and power logic
  function automatic logic ch_off(input logic [4:0] ch);
    ch_off = (ch == CH_OFF);
  endfunction : ch_off

  // Start, abort and tick go in; busy, done and code come out
  acc_sar_if sar (); // Link to the engine

  // Synchronisers: comparator, local clock, trigger
  logic [1:0] cmp_s_reg, cmp_s_next;
  logic [2:0] loc_s_reg, loc_s_next; // Two sync stages, one history
  logic [2:0] hwt_s_reg, hwt_s_next; // Two sync stages, one history
  // Conversion clock helpers
  logic div_reg, div_next; // Bus divide by two
  logic lp_reg, lp_next;   // Low power skip
  logic raw_tick;          // Qualified source edge
  // Registers seen by software
  logic [4:0] ch_reg, ch_next;      // Channel select
  logic ien_reg, ien_next;          // Interrupt enable
  logic cont_reg, cont_next;        // Continuous select
  logic done_reg, done_next;        // Conversion done flag
  logic hwt_reg, hwt_next;          // Hardware trigger enable
  logic cmpe_reg, cmpe_next;        // Compare enable
  logic cmpge_reg, cmpge_next;      // Compare greater-or-equal
  logic [9:0] cmpv_reg, cmpv_next;  // Compare value
  logic [7:0] cfg_reg, cfg_next;    // Configuration
  logic [3:0] pen_reg, pen_next;    // Analog pin enables
  logic [9:0] res_reg, res_next;    // Formatted result
  // Bus answer
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  // Analog side outputs and interrupt
  logic [3:0] route_reg, route_next;
  logic temp_reg, temp_next;
  logic bg_reg, bg_next;
  logic pwr_reg, pwr_next;
  logic irq_reg, irq_next;
  // Decoded bus events and trigger edge
  logic wr_acc, rd_acc, setup, sc1_wr, lo_rd, hw_evt;
  logic [9:0] fmt;   // Result in chosen width
  logic cmp_true;    // Compare outcome

  acc_sar_engine u_engine (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .sar(sar.eng)
  );

  // Synchroniser shift for pins from outside the clock
  // Two flops before any logic reads a pin; the third
  // stage of clock and trigger only keeps edge history
  always_comb begin
    cmp_s_next = {cmp_s_reg[0], cmp_above_pin};
    loc_s_next = {loc_s_reg[1:0], local_async_conv_clock};
    hwt_s_next = {hwt_s_reg[1:0], hw_conversion_trigger};
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cmp_s_reg <= 2'h0;
      loc_s_reg <= 3'h0;
      hwt_s_reg <= 3'h0;
    end else begin
      cmp_s_reg <= cmp_s_next;
      loc_s_reg <= loc_s_next;
      hwt_s_reg <= hwt_s_next;
    end
  end

  // Conversion clock choice and low power slowing
  // The alternate clock is absent, so its code never ticks
  // Low power passes only every second source tick
  always_comb begin
    case (cfg_reg[1:0])
      CLK_BUS: raw_tick = 1'b1;
      CLK_BUS_DIV2: raw_tick = div_reg;
      CLK_ALT: raw_tick = 1'b0;
      CLK_LOCAL: raw_tick = loc_s_reg[1] & ~loc_s_reg[2];
      default: raw_tick = 1'b0;
    endcase
    div_next = ~div_reg;
    lp_next = raw_tick ? ~lp_reg : lp_reg;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      div_reg <= 1'b0;
      lp_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      lp_reg <= lp_next;
    end
  end

  // Engine inputs
  // The comparator is read only after both sync stages
  assign sar.tick = raw_tick & (~cfg_reg[CFG_LPWR] | lp_reg);
  assign sar.long_sample = cfg_reg[CFG_LSMP];
  assign sar.cmp_above = cmp_s_reg[1];

  // Bus phase decode
  // Zero wait: pready is up in the first access cycle,
  // so a write acts at the edge that ends that cycle
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pready_reg & pwrite;
  assign rd_acc = psel & penable & pready_reg & ~pwrite;
  assign sc1_wr = wr_acc & (paddr == OFS_SC1);
  assign lo_rd = rd_acc & (paddr == OFS_RES_LO);
  assign hw_evt = hwt_s_reg[1] & ~hwt_s_reg[2];

  // Result formatting and compare
  // Eight-bit mode drops the two lowest result bits
  always_comb begin
    fmt = cfg_reg[CFG_TEN] ? sar.result : {2'h0, sar.result[9:2]};
    cmp_true = cmpge_reg ? (fmt >= cmpv_reg) : (fmt < cmpv_reg);
  end

  // Register writes and conversion control
  // A control write always aborts; it restarts only in
  // software trigger mode with the converter on.
  // Hardware triggers that come while busy are dropped
  always_comb begin
    ch_next = ch_reg;
    ien_next = ien_reg;
    cont_next = cont_reg;
    hwt_next = hwt_reg;
    cmpe_next = cmpe_reg;
    cmpge_next = cmpge_reg;
    cmpv_next = cmpv_reg;
    cfg_next = cfg_reg;
    pen_next = pen_reg;
    res_next = res_reg;
    sar.start = 1'b0;
    sar.abort = 1'b0;
    // Fields change at the edge that ends the access
    if (wr_acc) begin
      case (paddr)
        OFS_SC1: begin
          ch_next = pwdata[4:0];
          ien_next = pwdata[SC1_IEN];
          cont_next = pwdata[SC1_CONT];
        end
        OFS_SC2: begin
          hwt_next = pwdata[SC2_HWT];
          cmpe_next = pwdata[SC2_CMPE];
          cmpge_next = pwdata[SC2_CMPGE];
        end
        OFS_CMP: cmpv_next = pwdata[9:0];
        OFS_CFG: cfg_next = pwdata[7:0];
        OFS_PIN: pen_next = pwdata[3:0];
        default: ;
      endcase
    end
    if (sc1_wr) begin
      // Abort and restart in software trigger mode
      sar.abort = 1'b1;
      sar.start = ~ch_off(pwdata[4:0]) & ~hwt_reg;
    end else if (ch_off(ch_reg)) begin
      sar.abort = 1'b1;
    end else if (hwt_reg & hw_evt & ~sar.busy) begin
      sar.start = 1'b1;
    end else if (sar.done & cont_reg) begin
      sar.start = 1'b1;
    end
    // Result kept only when the flag would be set
    if (sar.done & (~cmpe_reg | cmp_true)) begin
      res_next = fmt;
    end
  end

  // Done flag: a new set beats a clear in the same cycle
  // The interrupt follows the flag and the enable together
  always_comb begin
    done_next = (sar.done & (~cmpe_reg | cmp_true))
              | (done_reg & ~(sc1_wr | lo_rd));
    irq_next = done_next & ien_next;
  end

  // Read data and answer, captured in the setup cycle
  // Taking the word in setup keeps it stable through access
  always_comb begin
    prdata_next = 32'h0000_0000;
    pslverr_next = 1'b0;
    pready_next = setup;
    // Unmapped places answer with an error and read zero
    if (setup & ~pwrite) begin
      case (paddr)
        OFS_SC1: prdata_next[7:0] = {done_reg, ien_reg, cont_reg, ch_reg};
        OFS_SC2: prdata_next[7:0] = {sar.busy, hwt_reg, cmpe_reg,
                                     cmpge_reg, 4'h0};
        OFS_RES_HI: prdata_next[1:0] = res_reg[9:8];
        OFS_RES_LO: prdata_next[7:0] = res_reg[7:0];
        OFS_CMP: prdata_next[9:0] = cmpv_reg;
        OFS_CFG: prdata_next[7:0] = cfg_reg;
        OFS_PIN: prdata_next[3:0] = pen_reg;
        default: pslverr_next = 1'b1; // Unmapped read
      endcase
    end else if (setup) begin
      case (paddr)
        OFS_SC1, OFS_SC2, OFS_RES_HI, OFS_RES_LO,
        OFS_CMP, OFS_CFG, OFS_PIN: pslverr_next = 1'b0;
        default: pslverr_next = 1'b1; // Unmapped write
      endcase
    end
  end

  // Analog multiplexer controls
  // One route bit per implemented pin
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_route
      // Pin routed only when selected and enabled
      assign route_next[gi] = (ch_next == 5'(gi)) & pen_next[gi];
    end
  endgenerate

  // Selects follow the channel as it is written; power
  // stays up from a start until the engine is idle
  always_comb begin
    temp_next = (ch_next == CH_TEMP);
    bg_next = (ch_next == CH_BANDGAP);
    pwr_next = ~ch_off(ch_next) & (sar.start | sar.busy);
  end

  // Register everything software and the analog side see, except the sample switch and trial code
  // The channel resets to the off code, converter unpowered
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ch_reg <= SC1_CH_RST;
      ien_reg <= 1'b0;
      cont_reg <= 1'b0;
      done_reg <= 1'b0;
      hwt_reg <= 1'b0;
      cmpe_reg <= 1'b0;
      cmpge_reg <= 1'b0;
      cmpv_reg <= 10'h000;
      cfg_reg <= {6'h00, CFG_CLK_RST};
      pen_reg <= 4'h0;
      res_reg <= 10'h000;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      route_reg <= 4'h0;
      temp_reg <= 1'b0;
      bg_reg <= 1'b0;
      pwr_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      ch_reg <= ch_next;
      ien_reg <= ien_next;
      cont_reg <= cont_next;
      done_reg <= done_next;
      hwt_reg <= hwt_next;
      cmpe_reg <= cmpe_next;
      cmpge_reg <= cmpge_next;
      cmpv_reg <= cmpv_next;
      cfg_reg <= cfg_next;
      pen_reg <= pen_next;
      res_reg <= res_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      route_reg <= route_next;
      temp_reg <= temp_next;
      bg_reg <= bg_next;
      pwr_reg <= pwr_next;
      irq_reg <= irq_next;
    end
  end

  // Outputs straight from flops
  // Sample switch and trial code come from engine flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign channel_select = ch_reg;
  assign pin_route = route_reg;
  assign pin_enable = pen_reg;
  assign temp_sensor_sel = temp_reg;
  assign bandgap_sel = bg_reg;
  assign sar_power_on = pwr_reg;
  assign sample_en = sar.sample_en;
  assign dac_code = sar.dac_code;
  assign conv_irq = irq_reg;
endmodule : acc_top
`default_nettype wire

// ---- verification/acc_top_chk.sv ----
/*
  Port checker for the converter control top.
  Assumes it is bound to acc_top and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module acc_top_chk (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [acc_pkg::ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic [4:0] channel_select,
  input wire logic [acc_pkg::NUM_PINS-1:0] pin_route,
  input wire logic [acc_pkg::NUM_PINS-1:0] pin_enable,
  input wire logic temp_sensor_sel,
  input wire logic bandgap_sel,
  input wire logic sar_power_on,
  input wire logic sample_en,
  input wire logic [acc_pkg::RES_W-1:0] dac_code,
  input wire logic conv_irq
);
  import acc_pkg::*;
  // One clock domain, one reset
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_pin_route: assert property (
    $stable(channel_select) && $stable(pin_enable) |-> pin_route ==
    ((channel_select <= CH_PIN_LAST) ?
    (pin_enable & (4'h1 << channel_select[1:0])) : 4'h0))
    else $error("pin route does not follow channel and enable");
  a_temp_select: assert property (
    $stable(channel_select) |-> temp_sensor_sel == (channel_select == CH_TEMP))
    else $error("temperature select wrong");
  a_bandgap_select: assert property (
    $stable(channel_select) |-> bandgap_sel == (channel_select == CH_BANDGAP))
    else $error("bandgap select wrong");
  a_off_quiet: assert property (
    (channel_select == CH_OFF)[*2] |-> !sar_power_on && !sample_en)
    else $error("converter active with channel off");
  a_sar_midscale: assert property (
    $fell(sample_en) && sar_power_on && !$past(psel) && !$past(psel, 2)
    |-> dac_code == 10'h200)
    else $error("first trial code is not mid scale");
  a_sample_power: assert property (
    sample_en |-> sar_power_on)
    else $error("sampling while powered down");
  a_irq_rise: assert property (
    $rose(conv_irq) |-> !$past(sample_en) && !sample_en)
    else $error("interrupt rose outside conversion end");
  a_done_clear: assert property (
    psel && penable && pready &&
    (pwrite ? paddr == OFS_SC1 : paddr == OFS_RES_LO) |=> !conv_irq)
    else $error("done not cleared by write or low read");
endmodule : acc_top_chk
bind acc_top acc_top_chk i_chk (.core_clk, .rst_b, .psel, .penable, .pwrite,
  .paddr, .pready, .channel_select, .pin_route, .pin_enable,
  .temp_sensor_sel, .bandgap_sel, .sar_power_on, .sample_en, .dac_code,
  .conv_irq);
`default_nettype wire

// ---- verification/acc_far_model.sv ----
/*
  Far-side model: analog input selector, comparator, overflow counter.
  Assumes the top's channel outputs and a free reference clock.
*/
`timescale 1ns/100ps
`default_nettype none
module acc_far_model #(
  parameter int PERIOD = 8
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ref_clk,
  input wire logic run,
  input wire logic [4:0] channel_select,
  input wire logic [3:0] pin_route,
  input wire logic temp_sensor_sel,
  input wire logic bandgap_sel,
  input wire logic [9:0] dac_code,
  input wire logic [39:0] pin_levels,
  input wire logic [9:0] temp_level,
  input wire logic [9:0] bg_level,
  output logic cmp_above_pin,
  output logic hw_conversion_trigger
);
  logic [9:0] lvl; // Level on the selected input
  logic live; // Some input is connected
  logic flip_reg; // Noise when nothing is connected
  int cnt; // Overflow counter
  // Input selection
  always_comb begin
    live = 1'b1;
    lvl = 10'h0; // Ground-tied codes
    if (pin_route != 4'h0) begin
      for (int i = 0; i < 4; i++) begin
        if (pin_route[i]) lvl = pin_levels[i*10 +: 10];
      end
    end else if (temp_sensor_sel) begin
      lvl = temp_level;
    end else if (bandgap_sel) begin
      lvl = bg_level;
    end else if (channel_select == 5'h1c || channel_select == 5'h1d) begin
      lvl = 10'h3ff; // High reference
    end else if (channel_select < 5'h04 ||
        (channel_select > 5'h15 && channel_select != 5'h1e)) begin
      live = 1'b0;
    end
  end
  // Half-step offset avoids ties
  assign cmp_above_pin = live ? ({lvl, 1'b1} > {dac_code, 1'b0}) : flip_reg;
  // Toggle pattern for floating input
  always_ff @(posedge core_clk) flip_reg <= rst_b ? ~flip_reg : 1'b0;
  // Free-running counter, one pulse per overflow
  always_ff @(posedge ref_clk) begin
    if (!run) begin
      cnt <= 0;
      hw_conversion_trigger <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      hw_conversion_trigger <= (cnt == PERIOD - 1);
    end
  end
endmodule : acc_far_model
`default_nettype wire

// ---- verification/tb_acc_top.sv ----
/*
  Self-checking bench for the converter control top.
  Assumes the far-side model and the checker are compiled beforehand.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_acc_top;
  import acc_pkg::*;
  logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr, err, ten;
  logic cmp_above_pin, local_async_conv_clock, hw_conversion_trigger;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [4:0] channel_select;
  logic [NUM_PINS-1:0] pin_route, pin_enable, pen;
  logic temp_sensor_sel, bandgap_sel, sar_power_on, sample_en, conv_irq;
  logic [RES_W-1:0] dac_code, temp_lvl, bg_lvl;
  logic [9:0] lv [4]; // Pin levels
  logic ref_clk, run;
  int fail_count, check_count, cycles, seed, n;
  acc_top i_dut (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cmp_above_pin,
    .local_async_conv_clock, .hw_conversion_trigger, .channel_select,
    .pin_route, .pin_enable, .temp_sensor_sel, .bandgap_sel, .sar_power_on,
    .sample_en, .dac_code, .conv_irq);
  acc_far_model i_far (.core_clk, .rst_b, .ref_clk, .run, .channel_select,
    .pin_route, .temp_sensor_sel, .bandgap_sel, .dac_code,
    .pin_levels({lv[3], lv[2], lv[1], lv[0]}), .temp_level(temp_lvl),
    .bg_level(bg_lvl), .cmp_above_pin, .hw_conversion_trigger);
  // Clocks: core, local converter, reference
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    local_async_conv_clock = 1'b0;
    #3;
    forever #7 local_async_conv_clock = ~local_async_conv_clock;
  end
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic final_report();
    if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic check(input string what, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One APB transfer, result in rd and err
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Wait for the answer; only the hang guard ends this
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_done(input int lim);
    n = 0;
    do begin
      apb(1'b0, OFS_SC1, 32'h0);
      n++;
    end while (rd[SC1_DONE] !== 1'b1 && n < lim);
  endtask : wait_done
  // Reference model of the converted level
  function automatic int expect_of(input int ch);
    if (ch < 4) return pen[ch] ? int'(lv[ch]) : -1;
    if (ch >= 22 && ch <= 25) return -1;
    if (ch == 26) return int'(temp_lvl);
    if (ch == 27) return int'(bg_lvl);
    return (ch == 28 || ch == 29) ? 1023 : 0;
  endfunction : expect_of
  // Start by software, wait, read and compare
  task automatic conv(input logic [7:0] sc, input int ex);
    logic [31:0] hi;
    apb(1'b1, OFS_SC1, {24'h0, sc});
    wait_done(400);
    check("done", 32'(rd[SC1_DONE]), 32'h1);
    check("idle", 32'(sar_power_on), 32'h0);
    check("irq", 32'(conv_irq), 32'(sc[SC1_IEN]));
    apb(1'b0, OFS_RES_HI, 32'h0);
    hi = rd;
    apb(1'b0, OFS_RES_LO, 32'h0);
    if (ex >= 0 && ten) check("res_hi", hi, 32'(ex >> 8));
    if (ex >= 0) check("res_lo", rd, 32'(ten ? ex & 255 : ex >> 2));
    apb(1'b0, OFS_SC1, 32'h0);
    check("done clear", 32'(rd[SC1_DONE]), 32'h0);
    check("irq clear", 32'(conv_irq), 32'h0);
  endtask : conv
  initial begin
    seed = 32'h2355;
    {psel, penable, pwrite, run, rst_b} = '0;
    paddr = '0;
    pwdata = '0;
    for (int i = 0; i < 4; i++) lv[i] = 10'($random(seed));
    lv[0] = lv[0] & 10'h3fe;
    temp_lvl = 10'($random(seed));
    bg_lvl = 10'($random(seed));
    pen = 4'($random(seed)) | 4'h3;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    // Reset values and an unmapped place
    apb(1'b0, OFS_SC1, 32'h0);
    check("sc1 reset", rd, 32'h1f);
    check("chan reset", 32'(channel_select), 32'(SC1_CH_RST));
    apb(1'b0, OFS_CFG, 32'h0);
    check("cfg reset", rd, 32'h0);
    apb(1'b1, 8'h1c, 32'hffff);
    check("slverr", 32'(err), 32'h1);
    apb(1'b0, 8'h1c, 32'h0);
    check("unmapped", rd, 32'h0);
    apb(1'b1, OFS_CFG, 32'h4);
    ten = 1'b1;
    apb(1'b1, OFS_PIN, 32'(pen));
    @(posedge core_clk);
    check("pin enable", 32'(pin_enable), 32'(pen));
    // Every code but off; bandgap buffer taken as on
    for (int c = 0; c < 31; c++) conv(8'(c), expect_of(c));
    conv(8'h42, expect_of(2));
    apb(1'b1, OFS_SC1, 32'h0);
    repeat (12) @(posedge core_clk);
    conv(8'h01, expect_of(1));
    apb(1'b1, OFS_CFG, 32'h0);
    ten = 1'b0;
    conv(8'h00, expect_of(0));
    apb(1'b1, OFS_CFG, 32'h95);
    ten = 1'b1;
    conv({3'h0, CH_TEMP}, expect_of(26));
    apb(1'b1, OFS_CFG, 32'h07);
    conv(8'h00, expect_of(0));
    apb(1'b1, OFS_CFG, 32'h04);
    // Compare: ge equal, ge above, less than
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, OFS_SC2, k == 2 ? 32'h20 : 32'h30);
      apb(1'b1, OFS_CMP, 32'(lv[0]) + 32'(k != 0));
      apb(1'b1, OFS_SC1, 32'h0);
      wait_done(100);
      check("cmp done", 32'(rd[SC1_DONE]), 32'(k != 1));
    end
    // Hardware trigger, one run per overflow
    apb(1'b1, OFS_SC2, 32'h40);
    apb(1'b1, OFS_SC1, 32'h01);
    run <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wait_done(400);
      check("hw done", 32'(rd[SC1_DONE]), 32'h1);
      apb(1'b0, OFS_RES_LO, 32'h0);
      check("hw res", rd, {24'h0, lv[1][7:0]});
    end
    run <= 1'b0;
    apb(1'b1, OFS_SC2, 32'h0);
    // Continuous runs, then off
    apb(1'b1, OFS_SC1, 32'h20);
    wait_done(400);
    apb(1'b0, OFS_RES_LO, 32'h0);
    wait_done(400);
    check("cont again", 32'(rd[SC1_DONE]), 32'h1);
    apb(1'b1, OFS_SC1, 32'h3f);
    // A run ending on the write may still set the flag; clear it
    apb(1'b0, OFS_RES_LO, 32'h0);
    repeat (80) @(posedge core_clk);
    check("off power", 32'(sar_power_on), 32'h0);
    apb(1'b0, OFS_SC1, 32'h0);
    check("off done", 32'(rd[SC1_DONE]), 32'h0);
    // Alternate clock gives no ticks
    apb(1'b1, OFS_CFG, 32'h06);
    apb(1'b1, OFS_SC1, 32'h0);
    wait_done(100);
    check("alt clock", 32'(rd[SC1_DONE]), 32'h0);
    apb(1'b1, OFS_SC1, 32'h1f);
    final_report();
  end
endmodule : tb_acc_top
`default_nettype wire
